// ### logic/pll_loop_filter_config.sv
// Functional notes
// R1: Cap one code, bits 2:0, resets zero; 5 pF plus 50 pF per step.
// R2: Resistor three code at bits 6:1, reset zero; every code is legal.
// R3: Software sets bit 0 low for integer loop, high for fractional; resets low.
// R4: Cap three code at bits 2:0, reset zero; capacitance is 5 pF per step.
// R5: Post divider select, bits 4:2, resets 7; codes 0,1 divide by 2, else code plus one.
// R6: Reserved bits read as zero and writes to them are ignored.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module pll_loop_filter_config
  import loop_filter_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output loop_codes_t            loop_codes,
  output loop_values_t           loop_values
);

  loop_codes_t  codes_r;
  loop_codes_t  codes_nxt;
  loop_values_t values_nxt;
  logic [31:0]  prdata_r;
  logic         pready_r;
  logic         pslverr_r;
  loop_values_t values_r;
  logic         wr_take;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == ADDR_CAP_ONE) || (a == ADDR_RES_THREE)
            || (a == ADDR_CAP_THREE) || (a == ADDR_SECOND_PLL_CONTROL_ZERO);
  endfunction

  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a, input loop_codes_t c);
    read_word = 32'h0000_0000;
    unique case (a)
      ADDR_CAP_ONE:    read_word[CAP_ONE_LSB +: 3] = c.first_loop_cap_one_code;
      ADDR_RES_THREE: begin
        read_word[RES_THREE_LSB +: 6] = c.first_loop_res_three_code;
        read_word[INT_FRAC_BIT]       = c.first_loop_integer_fraction_select;
      end
      ADDR_CAP_THREE:  read_word[CAP_THREE_LSB +: 3] = c.first_loop_cap_three_code;
      ADDR_SECOND_PLL_CONTROL_ZERO: read_word[POST_DIV_LSB +: 3] = c.second_loop_post_divider_select;
      default:         read_word = 32'h0000_0000;
    endcase
  endfunction

  // The answer is prepared in the setup cycle, so every access ends in its first access cycle.
  assign wr_take = psel && penable && pready_r && pwrite && addr_hit(paddr) && pstrb[0];

  always_comb begin
    codes_nxt = codes_r;
    if (wr_take) begin
      unique case (paddr)
        ADDR_CAP_ONE:
          codes_nxt.first_loop_cap_one_code = pwdata[CAP_ONE_LSB +: 3]; // R1 R6
        ADDR_RES_THREE: begin
          codes_nxt.first_loop_res_three_code = pwdata[RES_THREE_LSB +: 6]; // R2 R6
          codes_nxt.first_loop_integer_fraction_select = pwdata[INT_FRAC_BIT]; // R3
        end
        ADDR_CAP_THREE:
          codes_nxt.first_loop_cap_three_code = pwdata[CAP_THREE_LSB +: 3]; // R4 R6
        ADDR_SECOND_PLL_CONTROL_ZERO:
          codes_nxt.second_loop_post_divider_select = pwdata[POST_DIV_LSB +: 3]; // R5 R6
        default:
          codes_nxt = codes_r;
      endcase
    end
  end

  loop_value_decode u_decode (
    .codes  (codes_nxt),
    .values (values_nxt)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      codes_r.first_loop_cap_one_code            <= CAP_ONE_RST; // R1
      codes_r.first_loop_res_three_code          <= RES_THREE_RST; // R2
      codes_r.first_loop_integer_fraction_select <= INT_FRAC_RST; // R3
      codes_r.first_loop_cap_three_code          <= CAP_THREE_RST; // R4
      codes_r.second_loop_post_divider_select    <= POST_DIV_RST; // R5
    end else begin
      codes_r <= codes_nxt;
    end
  end

  // Physical settings follow the codes in the same edge, so both outputs stay in step.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      values_r.cap_one_pf        <= CAP_ONE_BASE_PF; // R1
      values_r.cap_three_pf      <= CAP_THREE_PF_RST; // R4
      values_r.post_divide_ratio <= POST_RATIO_RST; // R5
    end else begin
      values_r <= values_nxt; // R1 R4 R5
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready_r  <= 1'b1;
      pslverr_r <= !addr_hit(paddr);
      prdata_r  <= pwrite ? 32'h0000_0000 : read_word(paddr, codes_r); // R6
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
  end

  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign loop_codes  = codes_r;
  assign loop_values = values_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  // Each write sequence names the access cycle; except for s_write_no_strobe, the edge that ends it stores the data.
  sequence s_write_cap_one;
    psel && penable && pwrite && pstrb[0] && paddr == ADDR_CAP_ONE;
  endsequence

  sequence s_write_cap_three;
    psel && penable && pwrite && pstrb[0] && paddr == ADDR_CAP_THREE;
  endsequence

  sequence s_write_post_div;
    psel && penable && pwrite && pstrb[0] && paddr == ADDR_SECOND_PLL_CONTROL_ZERO;
  endsequence

  sequence s_write_no_strobe;
    psel && penable && pwrite && !pstrb[0];
  endsequence

  sequence s_access_unmapped;
    psel && penable && !addr_hit(paddr);
  endsequence

  a_cap_one_law: assert property ( // R1
    s_write_cap_one ##1 1'b1 |->
      loop_values.cap_one_pf == 9'(9'h005 + 9'h032 * {6'h00, $past(pwdata[2:0])}))
    else $error("cap one capacitance does not follow its code");

  a_res_three_field: assert property ( // R2
    psel && penable && pwrite && pstrb[0] && paddr == ADDR_RES_THREE |=>
      loop_codes.first_loop_res_three_code == $past(pwdata[6:1]))
    else $error("resistor three code not taken from bits 6 to 1");

  a_cap_three_law: assert property ( // R4
    loop_values.cap_three_pf == 6'(6'h05 * {3'h0, loop_codes.first_loop_cap_three_code}))
    else $error("cap three capacitance does not follow its code");

  a_post_div_ratio: assert property ( // R5
    loop_values.post_divide_ratio ==
      ((loop_codes.second_loop_post_divider_select < 3'h2) ? 4'h2 :
       {1'b0, loop_codes.second_loop_post_divider_select} + 4'h1))
    else $error("post divider ratio does not match its select code");

  a_reserved_reads_zero: assert property ( // R6
    s_setup ##1 (psel && penable && !pwrite) |->
      (paddr == ADDR_RES_THREE ? prdata[31:7] == 25'h0 :
       paddr == ADDR_SECOND_PLL_CONTROL_ZERO ? (prdata[31:5] == 27'h0 && prdata[1:0] == 2'h0) :
       prdata[31:3] == 29'h0))
    else $error("reserved bits read back nonzero");

  a_answer_one_cycle: assert property (
    s_setup |=> pready)
    else $error("access phase not answered in its first cycle");

  // Stored fields are checked one edge after the write, once the code register has settled.
  a_cap_one_field: assert property ( // R1
    s_write_cap_one |=> loop_codes.first_loop_cap_one_code == $past(pwdata[2:0]))
    else $error("cap one code not taken from bits 2 to 0");

  a_int_frac_bit: assert property ( // R3
    psel && penable && pwrite && pstrb[0] && paddr == ADDR_RES_THREE |=>
      loop_codes.first_loop_integer_fraction_select == $past(pwdata[0]))
    else $error("integer or fractional select not taken from bit 0");

  a_cap_three_field: assert property ( // R4
    s_write_cap_three |=> loop_codes.first_loop_cap_three_code == $past(pwdata[2:0]))
    else $error("cap three code not taken from bits 2 to 0");

  a_post_div_field: assert property ( // R5
    s_write_post_div |=> loop_codes.second_loop_post_divider_select == $past(pwdata[4:2]))
    else $error("post divider select not taken from bits 4 to 2");

  // The cap one value is one to one with its code, so the two must move together.
  a_cap_one_step: assert property ( // R1
    $changed(loop_codes.first_loop_cap_one_code) |-> $changed(loop_values.cap_one_pf))
    else $error("cap one capacitance did not move with its code");

  // A write without its low byte strobe must leave every code as it was.
  a_strobe_ignored: assert property (
    s_write_no_strobe |=> $stable(loop_codes))
    else $error("write without low byte strobe changed a code");

  a_unmapped_error: assert property (
    s_access_unmapped |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not answered with an error and zero data");

  a_unmapped_no_write: assert property ( // R6
    s_access_unmapped |=> $stable(loop_codes))
    else $error("unmapped write changed a code");

  // Outside an answer the bus outputs rest at zero, so stale read data never leaks out.
  a_idle_quiet: assert property (
    !pready |-> !pslverr && prdata == 32'h0000_0000)
    else $error("read data or error shown without an answer");

endmodule

// ### logic/loop_filter_pkg.sv
package loop_filter_pkg;

  // Register indices; the bus byte address is four times the index.
  localparam logic [7:0]  IDX_CAP_ONE     = 8'h44;
  localparam logic [7:0]  IDX_RES_THREE   = 8'h45;
  localparam logic [7:0]  IDX_CAP_THREE   = 8'h46;
  localparam logic [7:0]  IDX_SECOND_PLL_CONTROL_ZERO  = 8'h47;
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] ADDR_CAP_ONE    = {2'h0, IDX_CAP_ONE, 2'h0};
  localparam logic [11:0] ADDR_RES_THREE  = {2'h0, IDX_RES_THREE, 2'h0};
  localparam logic [11:0] ADDR_CAP_THREE  = {2'h0, IDX_CAP_THREE, 2'h0};
  localparam logic [11:0] ADDR_SECOND_PLL_CONTROL_ZERO = {2'h0, IDX_SECOND_PLL_CONTROL_ZERO, 2'h0};

  // Field positions.
  localparam int CAP_ONE_LSB    = 0;
  localparam int CAP_THREE_LSB  = 0;
  localparam int INT_FRAC_BIT   = 0;
  localparam int RES_THREE_LSB  = 1;
  localparam int POST_DIV_LSB   = 2;

  // Values after reset.
  localparam logic [2:0] CAP_ONE_RST   = 3'h0;
  localparam logic [5:0] RES_THREE_RST = 6'h00;
  localparam logic       INT_FRAC_RST  = 1'b0;
  localparam logic [2:0] CAP_THREE_RST = 3'h0;
  localparam logic [2:0] POST_DIV_RST  = 3'h7;
  localparam logic [5:0] CAP_THREE_PF_RST = 6'h00;
  localparam logic [3:0] POST_RATIO_RST   = 4'h8;

  // Capacitance law in pF.
  localparam logic [8:0] CAP_ONE_BASE_PF  = 9'h005;
  localparam logic [8:0] CAP_ONE_STEP_PF  = 9'h032;
  localparam logic [5:0] CAP_THREE_STEP_PF = 6'h05;

  typedef struct packed {
    logic [2:0] first_loop_cap_one_code;
    logic [5:0] first_loop_res_three_code;
    logic       first_loop_integer_fraction_select;
    logic [2:0] first_loop_cap_three_code;
    logic [2:0] second_loop_post_divider_select;
  } loop_codes_t;

  typedef struct packed {
    logic [8:0] cap_one_pf;
    logic [5:0] cap_three_pf;
    logic [3:0] post_divide_ratio;
  } loop_values_t;

endpackage

// ### logic/loop_value_decode.sv
`timescale 1ns/1ps
module loop_value_decode
  import loop_filter_pkg::*;
(
  input  loop_codes_t  codes,
  output loop_values_t values
);

  function automatic logic [3:0] post_ratio(input logic [2:0] sel);
    // Codes 0 and 1 both divide by two; above that the ratio is code plus one.
    post_ratio = (sel == 3'h0) ? 4'h2 : ({1'b0, sel} + 4'h1);
  endfunction

  always_comb begin
    values.cap_one_pf        = CAP_ONE_BASE_PF
                             + 9'(CAP_ONE_STEP_PF * {6'h00, codes.first_loop_cap_one_code});
    values.cap_three_pf      = 6'(CAP_THREE_STEP_PF * {3'h0, codes.first_loop_cap_three_code});
    values.post_divide_ratio = post_ratio(codes.second_loop_post_divider_select);
  end

endmodule

// ### sim/test_pll_loop_filter_config.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_pll_loop_filter_config;
  import loop_filter_pkg::*;
  logic              pclk    = 1'b0;
  logic              presetn = 1'b0;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [ADDR_W-1:0] paddr   = '0;
  logic [31:0]       pwdata  = '0;
  logic [3:0]        pstrb   = 4'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  loop_codes_t       codes;
  loop_values_t      vals;
  int                bad_count   = 0;
  int                checks_done = 0;
  int                cycles      = 0;
  integer            seed        = 32'h9938;
  logic [33:0]       notes[$];
  logic [33:0]       note;
  logic [31:0]       d;

  pll_loop_filter_config uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .loop_codes(codes), .loop_values(vals));

  always #25 pclk = ~pclk;

  task automatic stop_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Called just after a rising edge; returns at the edge that sampled pready high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] s, input logic err, input logic [31:0] exp);
    notes.push_back({~w, err, exp});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
  endtask

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end

  // Takes the oldest note whenever the slave answers.
  always @(posedge pclk) begin
    if (presetn === 1'b1 && pready === 1'b1) begin
      if (notes.size() == 0) begin
        bad_count++;
        $display("[ERR] %0t answer without request", $time);
      end else begin
        note = notes.pop_front();
        `CHK(pslverr, note[32])
        if (note[33]) `CHK(prdata, note[31:0])
      end
    end
  end

  initial begin
    repeat (10) @(posedge pclk);
    `CHK(codes, {3'h0, 6'h00, 1'b0, 3'h0, 3'h7})
    `CHK(vals, {9'h005, 6'h00, 4'h8})
    presetn <= 1'b1;
    apb(0, ADDR_CAP_ONE, 0, 4'hf, 0, 32'h0);
    apb(0, ADDR_RES_THREE, 0, 4'hf, 0, 32'h0);
    apb(0, ADDR_CAP_THREE, 0, 4'hf, 0, 32'h0);
    apb(0, ADDR_SECOND_PLL_CONTROL_ZERO, 0, 4'hf, 0, 32'h1c);
    // Back-to-back writes of all ones; reserved bits must not stick.
    apb(1, ADDR_CAP_ONE, '1, 4'hf, 0, 0);
    apb(1, ADDR_RES_THREE, '1, 4'hf, 0, 0);
    apb(1, ADDR_CAP_THREE, '1, 4'hf, 0, 0);
    apb(1, ADDR_SECOND_PLL_CONTROL_ZERO, '1, 4'hf, 0, 0);
    apb(0, ADDR_CAP_ONE, 0, 4'hf, 0, 32'h07);
    apb(0, ADDR_RES_THREE, 0, 4'hf, 0, 32'h7f);
    apb(0, ADDR_CAP_THREE, 0, 4'hf, 0, 32'h07);
    apb(0, ADDR_SECOND_PLL_CONTROL_ZERO, 0, 4'hf, 0, 32'h1c);
    apb(1, ADDR_CAP_ONE, 0, 4'he, 0, 0);
    apb(0, ADDR_CAP_ONE, 0, 4'hf, 0, 32'h07);
    apb(1, 12'h120, '1, 4'hf, 1, 0);
    apb(0, 12'h120, 0, 4'hf, 1, 32'h0);
    apb(0, 12'h000, 0, 4'hf, 1, 32'h0);
    for (int c = 0; c < 8; c++) begin
      apb(1, ADDR_CAP_ONE, 32'(c), 4'hf, 0, 0);
      apb(1, ADDR_CAP_THREE, 32'(c), 4'hf, 0, 0);
      apb(1, ADDR_SECOND_PLL_CONTROL_ZERO, 32'(c << 2), 4'hf, 0, 0);
      idle();
      `CHK(vals.cap_one_pf, 9'(5 + 50 * c))
      `CHK(vals.cap_three_pf, 6'(5 * c))
      `CHK(vals.post_divide_ratio, 4'((c < 2) ? 2 : c + 1))
      `CHK(codes.second_loop_post_divider_select, 3'(c))
      `CHK(codes.first_loop_cap_one_code, 3'(c))
      `CHK(codes.first_loop_cap_three_code, 3'(c))
    end
    repeat (8) begin
      d = $random(seed);
      apb(1, ADDR_RES_THREE, d, 4'hf, 0, 0);
      idle();
      `CHK(codes.first_loop_res_three_code, d[6:1])
      `CHK(codes.first_loop_integer_fraction_select, d[0])
      apb(0, ADDR_RES_THREE, 0, 4'hf, 0, {25'h0, d[6:0]});
    end
    idle();
    // Reset in mid-run must bring every code back, whatever was written before.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(codes, {3'h0, 6'h00, 1'b0, 3'h0, 3'h7})
    `CHK(vals, {9'h005, 6'h00, 4'h8})
    presetn <= 1'b1;
    apb(0, ADDR_CAP_ONE, 0, 4'hf, 0, 32'h0);
    apb(0, ADDR_RES_THREE, 0, 4'hf, 0, 32'h0);
    idle();
    idle();
    `CHK(notes.size(), 0)
    stop_test();
  end
endmodule
